// *** pkg/core_command_pkg.sv ***
// Constants and carrier types for the core command register block.
// Assumes a single 50 MHz core clock and an 8-bit indexed register port.
package core_command_pkg;

    localparam int          DATA_W        = 8;
    localparam int          INDEX_W       = 4;
    localparam logic [3:0]  CMD_INDEX     = 4'h0;
    localparam logic [3:0]  STATUS_INDEX  = 4'h7;
    localparam logic [1:0]  PAGE_STATUS   = 2'h0;

    localparam int          HALT_POS      = 0;
    localparam int          ACT_POS       = 1;
    localparam int          SEND_POS      = 2;
    localparam int          XFER_LSB      = 3;
    localparam int          XFER_MSB      = 5;
    localparam int          ABORT_POS     = 5;
    localparam int          BANK_LSB      = 6;
    localparam int          BANK_MSB      = 7;
    localparam int          RESET_DONE_POS = 7;

    localparam logic        HALT_RESET    = 1'b1;
    localparam logic        ACT_RESET     = 1'b0;
    localparam logic [2:0]  XFER_RESET    = 3'h4;
    localparam logic [1:0]  BANK_RESET    = 2'h0;

    localparam logic [2:0]  XFER_NONE     = 3'h0;
    localparam logic [2:0]  XFER_READ     = 3'h1;
    localparam logic [2:0]  XFER_WRITE    = 3'h2;
    localparam logic [2:0]  XFER_SEND     = 3'h3;

    localparam logic [1:0]  BANK_RESERVED = 2'h3;

    typedef enum logic [3:0] {
        ST_HALTED   = 4'h1,
        ST_DRAINING = 4'h2,
        ST_RUNNING  = 4'h4,
        ST_UNUSED   = 4'h8
    } core_state_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_READ  = 4'h2,
        RX_WRITE = 4'h4,
        RX_SEND  = 4'h8
    } xfer_kind_t;

    typedef struct packed {
        logic [1:0] bank;
        logic [2:0] xfer;
        logic       send;
        logic       act;
        logic       halt;
    } command_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [3:0] index;
        logic [7:0] data;
    } host_access_t;

endpackage : core_command_pkg

// *** rtl/core_command.sv ***
// Command register of the network core: start/stop, transmit launch,
// remote transfer commands and register page select.
// Assumes host port signals are already synchronous to clk_i and that
// the frame engines report their activity as levels and completion as clocked pulses.
`timescale 1ns/1ps

// Summary of operation
// - Halt takes the core off-line; no frame accepted or sent while halted; here a send written with halt while running still starts a frame.
// - A halt request waits for frames under way to finish first.
// - Host clears halt and sets activate; core then resumes operation.
// - Reset-done flag in event status goes to 1 once reset takes effect; here power-up reset clears it to 0.
// - Power-up holds halt high and activate low.
// - Halt written while started keeps both halt and activate set.
// - Setting activate brings the core into operation after any reset.
// - Send trigger starts one frame; cleared when it completes or aborts.
// - Writing 0 to the send trigger leaves it unchanged.
// - Transfer code: 000 illegal, 001 read, 010 write, 011 send, 1xx abort.
// - Reissued transfer with send trigger and no count reload ends at once.
// - Bank select 00/01/10 picks page 0/1/2; 11 is reserved.
// - Registers are 8 bits; a 4-bit index picks one within the page.
// - Reset-done sets entering reset, clears on start; host writes ignored.
module core_command
    import core_command_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                host_write_i,
    input  wire logic                host_read_i,
    input  wire logic [INDEX_W-1:0]  reg_index_lines_i,
    input  wire logic [DATA_W-1:0]   host_wdata_i,
    input  wire logic                rx_busy_i,
    input  wire logic                tx_busy_i,
    input  wire logic                tx_done_i,
    input  wire logic                tx_abort_i,
    input  wire logic                xfer_done_i,
    input  wire logic                count_reloaded_i,
    output logic [DATA_W-1:0]        host_rdata_o,
    output logic                     cmd_sel_o,
    output logic [1:0]               page_o,
    output logic                     page_reserved_o,
    output logic                     halt_bit_o,
    output logic                     activate_bit_o,
    output logic                     send_frame_trigger_o,
    output logic                     tx_start_o,
    output logic [2:0]               remote_xfer_cmd_o,
    output logic                     xfer_read_o,
    output logic                     xfer_write_o,
    output logic                     xfer_send_o,
    output logic                     xfer_stop_o,
    output logic                     core_online_o,
    output logic                     reset_done_o
);

    command_t      cmd_q;
    core_state_t   state_q;
    core_state_t   state_d;
    logic          online_q;
    logic          bank_rsv_q;
    xfer_kind_t    xfer_q;
    logic          reset_done_q;
    logic          tx_start_q;
    logic          xfer_stop_q;
    logic [7:0]    rdata_q;
    logic          cmd_sel_q;
    host_access_t  acc;
    command_t      wcmd;
    logic          cmd_wr;
    logic          tx_launch;
    logic          frames_idle;
    logic          xfer_abort;
    logic          xfer_start;
    logic          xfer_reissue;

    function automatic xfer_kind_t decode_xfer(input logic [2:0] code);
        xfer_kind_t k;
        k = RX_IDLE;
        if (code == XFER_READ)
            k = RX_READ;
        else if (code == XFER_WRITE)
            k = RX_WRITE;
        else if (code == XFER_SEND)
            k = RX_SEND;
        return k;
    endfunction : decode_xfer

    assign acc         = '{write: host_write_i, read: host_read_i,
                           index: reg_index_lines_i, data: host_wdata_i};
    assign wcmd        = command_t'(acc.data);
    // Index zero decodes in every page, reserved page included
    assign cmd_wr      = acc.write && (acc.index == CMD_INDEX);
    assign frames_idle = !rx_busy_i && !tx_busy_i;
    assign tx_launch   = cmd_wr && wcmd.send && !cmd_q.send
                         && (state_q == ST_RUNNING);
    assign xfer_abort  = cmd_wr && wcmd.xfer[2];
    assign xfer_start  = cmd_wr && !wcmd.xfer[2] && (wcmd.xfer != XFER_NONE)
                         && (state_q == ST_RUNNING);
    // Same transfer rewritten alongside a launch with no fresh count
    assign xfer_reissue = xfer_start && wcmd.send && (xfer_q != RX_IDLE)
                          && (decode_xfer(wcmd.xfer) == xfer_q)
                          && !count_reloaded_i;

    // Halt and start bits
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cmd_q.halt <= HALT_RESET;
            cmd_q.act  <= ACT_RESET;
        end
        else if (cmd_wr)
        begin
            cmd_q.halt <= wcmd.halt;
            // Activate stays set when halt follows a started core
            cmd_q.act  <= wcmd.act
                          || (wcmd.halt && (cmd_q.act || state_q == ST_RUNNING));
        end
    end

    // Core run state; halt drains frames in flight before going off-line
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_HALTED:
                if (cmd_wr && !wcmd.halt && wcmd.act)
                    state_d = ST_RUNNING;
            ST_RUNNING:
                if (cmd_wr && wcmd.halt)
                    state_d = frames_idle ? ST_HALTED : ST_DRAINING;
            ST_DRAINING:
                if (frames_idle)
                    state_d = ST_HALTED;
            default:
                state_d = ST_HALTED;
        endcase
    end

    // Online flag has its own flop so the port comes straight from a register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q  <= ST_HALTED;
            online_q <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            online_q <= (state_d != ST_HALTED);
        end
    end

    // Reset-done: entering reset wins over the start clear
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            reset_done_q <= 1'b0;
        else if ((state_q == ST_DRAINING && frames_idle)
                 || (state_q == ST_RUNNING && cmd_wr && wcmd.halt && frames_idle))
            reset_done_q <= 1'b1;
        else if (cmd_wr && wcmd.act && !wcmd.halt)
            reset_done_q <= 1'b0;
    end

    // Send trigger: a zero write is ignored, hardware clears on finish
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cmd_q.send <= 1'b0;
            tx_start_q <= 1'b0;
        end
        else
        begin
            tx_start_q <= tx_launch;
            if (tx_launch)
                cmd_q.send <= 1'b1;
            else if (cmd_q.send && (tx_done_i || tx_abort_i))
                cmd_q.send <= 1'b0;
        end
    end

    // Remote transfer command; a new launch wins over a completion clear
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cmd_q.xfer  <= XFER_RESET;
            xfer_q      <= RX_IDLE;
            xfer_stop_q <= 1'b0;
        end
        else
        begin
            xfer_stop_q <= 1'b0;
            if (xfer_abort)
            begin
                cmd_q.xfer  <= wcmd.xfer;
                xfer_q      <= RX_IDLE;
                xfer_stop_q <= (xfer_q != RX_IDLE);
            end
            else if (xfer_reissue)
            begin
                cmd_q.xfer  <= XFER_RESET;
                xfer_q      <= RX_IDLE;
                xfer_stop_q <= 1'b1;
            end
            else if (xfer_start)
            begin
                cmd_q.xfer <= wcmd.xfer;
                xfer_q     <= decode_xfer(wcmd.xfer);
            end
            else if (xfer_done_i && xfer_q != RX_IDLE)
            begin
                cmd_q.xfer <= XFER_RESET;
                xfer_q     <= RX_IDLE;
            end
        end
    end

    // Page select taken on every command write
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cmd_q.bank <= BANK_RESET;
            bank_rsv_q <= 1'b0;
        end
        else if (cmd_wr)
        begin
            cmd_q.bank <= wcmd.bank;
            bank_rsv_q <= (wcmd.bank == BANK_RESERVED);
        end
    end

    // Read data registered one cycle after the read strobe
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_q   <= 8'h00;
            cmd_sel_q <= 1'b0;
        end
        else
        begin
            cmd_sel_q <= acc.read && (acc.index == CMD_INDEX);
            if (acc.read && acc.index == CMD_INDEX)
                rdata_q <= cmd_q;
            else if (acc.read && acc.index == STATUS_INDEX && cmd_q.bank == PAGE_STATUS)
                rdata_q <= {reset_done_q, 7'h00};
            else
                rdata_q <= 8'h00;
        end
    end

    assign host_rdata_o         = rdata_q;
    assign cmd_sel_o            = cmd_sel_q;
    assign page_o               = cmd_q.bank;
    // Reserved page still decodes index zero; others should not respond
    assign page_reserved_o      = bank_rsv_q;
    assign halt_bit_o           = cmd_q.halt;
    assign activate_bit_o       = cmd_q.act;
    assign send_frame_trigger_o = cmd_q.send;
    assign tx_start_o           = tx_start_q;
    assign remote_xfer_cmd_o    = cmd_q.xfer;
    // One-hot kind register: each kind output is one of its flops
    assign xfer_read_o          = xfer_q[1];
    assign xfer_write_o         = xfer_q[2];
    assign xfer_send_o          = xfer_q[3];
    assign xfer_stop_o          = xfer_stop_q;
    assign core_online_o        = online_q;
    assign reset_done_o         = reset_done_q;

endmodule : core_command

// *** test/core_command_props.sv ***
// Port-level checks on the core command register block.
// Assumes it is bound to core_command; the bind follows the module.
`timescale 1ns/1ps
module core_command_props
    import core_command_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       host_write_i,
    input wire logic       host_read_i,
    input wire logic [3:0] reg_index_lines_i,
    input wire logic [7:0] host_wdata_i,
    input wire logic       rx_busy_i,
    input wire logic       tx_busy_i,
    input wire logic       tx_done_i,
    input wire logic       tx_abort_i,
    input wire logic [7:0] host_rdata_o,
    input wire logic       cmd_sel_o,
    input wire logic [1:0] page_o,
    input wire logic       page_reserved_o,
    input wire logic       halt_bit_o,
    input wire logic       activate_bit_o,
    input wire logic       send_frame_trigger_o,
    input wire logic       tx_start_o,
    input wire logic [2:0] remote_xfer_cmd_o,
    input wire logic       xfer_read_o,
    input wire logic       xfer_write_o,
    input wire logic       xfer_send_o,
    input wire logic       core_online_o,
    input wire logic       xfer_stop_o,
    input wire logic       reset_done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire cmd_wr = host_write_i && reg_index_lines_i == CMD_INDEX;
    wire running = core_online_o && !halt_bit_o;
    wire busy_x = xfer_read_o || xfer_write_o || xfer_send_o;
    logic [1:0] bank_wr_q;
    logic [7:0] cmd_now_q;
    // Snapshots let the checks compare against last cycle without $past on slices
    always_ff @(posedge clk_i) bank_wr_q <= host_wdata_i[BANK_MSB:BANK_LSB];
    always_ff @(posedge clk_i) cmd_now_q <= {page_o, remote_xfer_cmd_o,
                                             send_frame_trigger_o, activate_bit_o, halt_bit_o};
    a_power_up_bits: assert property ($rose(rst_n_i) |-> halt_bit_o && !activate_bit_o)
        else $error("halt or activate wrong after reset");
    a_start_resumes: assert property (cmd_wr && host_wdata_i[1:0] == 2'b10 && !core_online_o
        |=> running && activate_bit_o && !reset_done_o) else $error("start did not resume");
    a_send_launch: assert property (cmd_wr && host_wdata_i[SEND_POS] && !host_wdata_i[HALT_POS]
        && running && !send_frame_trigger_o |=> tx_start_o && send_frame_trigger_o ##1 !tx_start_o)
        else $error("frame launch wrong");
    a_send_clears: assert property ((tx_done_i || tx_abort_i) && !host_write_i
        |=> !send_frame_trigger_o) else $error("send trigger not cleared");
    a_halt_idle: assert property (cmd_wr && host_wdata_i[HALT_POS] && running && !rx_busy_i
        && !tx_busy_i |=> halt_bit_o && activate_bit_o && reset_done_o && !core_online_o)
        else $error("idle halt wrong");
    a_drain_wait: assert property (core_online_o && halt_bit_o && (rx_busy_i || tx_busy_i)
        |=> core_online_o && !reset_done_o) else $error("left before frames ended");
    a_abort_stops: assert property (cmd_wr && host_wdata_i[ABORT_POS] && busy_x
        |=> xfer_stop_o && !busy_x) else $error("abort did not stop transfer");
    a_page_follows: assert property (cmd_wr |=> page_o == bank_wr_q
        && page_reserved_o == (bank_wr_q == BANK_RESERVED)) else $error("page select wrong");
    a_read_back: assert property (host_read_i && reg_index_lines_i == CMD_INDEX && !host_write_i
        |=> cmd_sel_o && host_rdata_o == cmd_now_q) else $error("command read wrong");
    c_launch: cover property (tx_start_o);
    c_stop: cover property (xfer_stop_o);
    c_drain: cover property (core_online_o && halt_bit_o);
endmodule : core_command_props

bind core_command core_command_props u_props (.*);

// *** test/frame_engine_model.sv ***
// Behavioural frame and remote transfer engines facing the command block.
// Assumes the bench sets the length and holds rx_req_i for receive traffic.
`timescale 1ns/1ps
module frame_engine_model
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       tx_start_i,
    input  wire logic       tx_fail_i,
    input  wire logic       rx_req_i,
    input  wire logic       xfer_busy_i,
    input  wire logic [7:0] len_i,
    output logic            tx_busy_o,
    output logic            tx_done_o,
    output logic            tx_abort_o,
    output logic            rx_busy_o,
    output logic            xfer_done_o
);
    logic [7:0] tx_cnt_q;
    logic [7:0] xf_cnt_q;
    assign tx_busy_o = tx_cnt_q != 8'h00;
    assign rx_busy_o = rx_req_i;
    assign xfer_done_o = xfer_busy_i && xf_cnt_q == len_i;
    // A started frame always runs out; a halt never cuts it short
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_cnt_q   <= 8'h00;
            tx_done_o  <= 1'b0;
            tx_abort_o <= 1'b0;
        end
        else
        begin
            tx_done_o  <= tx_cnt_q == 8'h01 && !tx_fail_i;
            tx_abort_o <= tx_cnt_q == 8'h01 && tx_fail_i;
            tx_cnt_q   <= tx_start_i ? len_i : tx_cnt_q - {7'h00, tx_busy_o};
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            xf_cnt_q <= 8'h00;
        else
            // Count drop stands for the host clearing counts and its dummy port access
            xf_cnt_q <= xfer_busy_i ? xf_cnt_q + 8'h01 : 8'h00;
    end
endmodule : frame_engine_model

// *** test/testbench.sv ***
// Self-checking bench for the core command register with its engine model.
// Assumes a 50 MHz clock; host accesses come straight from tasks.
`timescale 1ns/1ps
module testbench;
    import core_command_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, host_write_i = 1'b0, host_read_i = 1'b0;
    logic [3:0] reg_index_lines_i = 4'h0;
    logic [7:0] host_wdata_i = 8'h00, len_q = 8'h01, host_rdata_o;
    logic rx_busy_i, tx_busy_i, tx_done_i, tx_abort_i, xfer_done_i, cmd_sel_o, page_reserved_o;
    logic count_reloaded_i = 1'b0, tx_fail_q = 1'b0, rx_req_q = 1'b0, halt_bit_o, activate_bit_o;
    logic send_frame_trigger_o, tx_start_o, xfer_read_o, xfer_write_o, xfer_send_o, xfer_stop_o;
    logic core_online_o, reset_done_o;
    logic [1:0] page_o;
    logic [2:0] remote_xfer_cmd_o;
    int fails = 0, n_compared = 0;
    always #10 clk_i = ~clk_i;
    core_command u_dut (.*);
    frame_engine_model u_eng (.clk_i(clk_i), .rst_n_i(rst_n_i), .tx_start_i(tx_start_o),
        .tx_fail_i(tx_fail_q), .rx_req_i(rx_req_q), .len_i(len_q), .rx_busy_o(rx_busy_i),
        .xfer_busy_i(xfer_read_o | xfer_write_o | xfer_send_o), .tx_busy_o(tx_busy_i),
        .tx_done_o(tx_done_i), .tx_abort_o(tx_abort_i), .xfer_done_o(xfer_done_i));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        host_write_i      <= 1'b1;
        reg_index_lines_i <= idx;
        host_wdata_i      <= d;
        @(posedge clk_i);
        host_write_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        @(posedge clk_i);
        host_read_i       <= 1'b1;
        reg_index_lines_i <= idx;
        @(posedge clk_i);
        host_read_i <= 1'b0;
        #1;
        check("read data", host_rdata_o, exp);
    endtask : rd
    // Waits for frame, transfer and drain to settle; bound covers the longest frame used
    task automatic wait_idle;
        int i;
        for (i = 0; i < 300 && (send_frame_trigger_o !== 1'b0 || xfer_read_o | xfer_write_o
             | xfer_send_o || core_online_o === 1'b1 && halt_bit_o === 1'b1); i++)
            @(posedge clk_i);
        #1;
        if (i == 300)
        begin
            fails++;
            wrap_up();
        end
    endtask : wait_idle
    task automatic t_send;
        rd(CMD_INDEX, 8'h21);
        wr(CMD_INDEX, 8'h22);
        check("online", core_online_o, 1'b1);
        len_q = 8'h06;
        for (int f = 0; f < 2; f++)
        begin
            tx_fail_q = f[0];
            wr(CMD_INDEX, 8'h26);
            check("tx start", tx_start_o, 1'b1);
            wr(CMD_INDEX, 8'h22);
            check("send kept", send_frame_trigger_o, 1'b1);
            wait_idle();
        end
        tx_fail_q = 1'b0;
        $display("test send done");
    endtask : t_send
    task automatic t_xfer;
        len_q = 8'hFF;
        for (int k = 1; k < 4; k++)
        begin
            wr(CMD_INDEX, {2'b00, k[2:0], 3'b010});
            check("kind", {5'h00, xfer_send_o, xfer_write_o, xfer_read_o}, 8'h01 << (k - 1));
            wr(CMD_INDEX, 8'h22);
            check("stop", xfer_stop_o, 1'b1);
        end
        wr(CMD_INDEX, 8'h1A);
        len_q = 8'h04;
        wr(CMD_INDEX, 8'h1E);
        check("reissue stop", xfer_stop_o, 1'b1);
        wait_idle();
        wr(CMD_INDEX, 8'h1A);
        @(posedge clk_i);
        count_reloaded_i <= 1'b1;
        wr(CMD_INDEX, 8'h1E);
        check("reload stop", xfer_stop_o, 1'b0);
        check("reload kept", xfer_send_o, 1'b1);
        @(posedge clk_i);
        count_reloaded_i <= 1'b0;
        wait_idle();
        wr(CMD_INDEX, 8'h12);
        wait_idle();
        check("field", remote_xfer_cmd_o, XFER_RESET);
        wr(CMD_INDEX, 8'h02);
        check("not allowed", {5'h00, xfer_send_o, xfer_write_o, xfer_read_o}, 8'h00);
        check("field kept", remote_xfer_cmd_o, XFER_RESET);
        $display("test xfer done");
    endtask : t_xfer
    task automatic t_pages;
        for (int b = 0; b < 4; b++)
        begin
            wr(CMD_INDEX, {b[1:0], 6'h22});
            check("reserved", page_reserved_o, b == 3);
            rd(CMD_INDEX, {b[1:0], 6'h22});
        end
        wr(CMD_INDEX, 8'h22);
        rd(4'h3, 8'h00);
        $display("test pages done");
    endtask : t_pages
    task automatic t_halt;
        len_q = 8'h08;
        rx_req_q = 1'b1;
        wr(CMD_INDEX, 8'h26);
        wr(CMD_INDEX, 8'h01);
        check("draining", core_online_o, 1'b1);
        rx_req_q = 1'b0;
        wait_idle();
        check("reset done", reset_done_o, 1'b1);
        rd(CMD_INDEX, 8'h23);
        wr(STATUS_INDEX, 8'h00);
        rd(STATUS_INDEX, 8'h80);
        wr(CMD_INDEX, 8'h05);
        check("no send", send_frame_trigger_o, 1'b0);
        wr(CMD_INDEX, 8'h22);
        check("cleared", reset_done_o, 1'b0);
        wr(CMD_INDEX, 8'h01);
        check("idle halt", core_online_o, 1'b0);
        $display("test halt done");
    endtask : t_halt
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_send();
        t_xfer();
        t_pages();
        t_halt();
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(CMD_INDEX, 8'h21);
        check("reset done off", reset_done_o, 1'b0);
        wrap_up();
    end
endmodule : testbench
